// ---- clk_mode_pkg.sv ----
// package for the system clock mode controller: control offsets, reset values, modes, state layout
// assumes a plain strobe register port and one reference clock
package clk_mode_pkg;

  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [3:0] OFS_SYS_ONE   = 4'h0;  // system_control_one: bit0 stop request
  localparam logic [3:0] OFS_SYS_TWO   = 4'h1;  // system_control_two
  localparam logic [3:0] OFS_TBT_CTRL  = 4'h2;  // base_timer_control
  localparam logic [3:0] OFS_IRQ_CTRL  = 4'h3;  // irq enables and latch
  localparam logic [3:0] OFS_STATUS    = 4'h4;  // mode and divider status
  localparam int         BIT_STOP      = 0;
  localparam int         BIT_IDLE      = 0;     // system_control_two fields
  localparam int         BIT_TIMING_GEN_HALT    = 1;
  localparam int         BIT_MAIN_CLOCK_SOURCE_SELECT     = 2;
  localparam int         BIT_XEN       = 3;
  localparam int         BIT_XTEN      = 4;     // low oscillator enable
  localparam int         BIT_BASE_TIMER_ENABLE     = 0;     // base_timer_control fields
  localparam int         BIT_DV7       = 1;
  localparam int         BIT_TBTSEL    = 2;     // 2 bits, tap select
  localparam int         BIT_IMF       = 0;     // irq control fields
  localparam int         BIT_EF6       = 1;
  localparam int         BIT_LATCH     = 2;
  localparam logic [7:0] SYS_TWO_RST   = 8'h08; // high osc on after reset
  localparam int         PRE_STAGES    = 2;
  localparam int         DIV_STAGES    = 21;
  localparam int         STATES_PER_MC = 4;
  localparam logic [15:0] WARMUP_CYC   = 16'h0100;  // stop warm-up length in reference cycles
  localparam int         REF_MHZ       = 125;
  localparam int         LOW_DIV       = REF_MHZ;  // reference cycles per low-clock tick (model)

  // ****************************************
  // operating modes (gray along normal path)
  // ****************************************
  typedef enum logic [3:0] {
    M_NORMAL1 = 4'h0,
    M_IDLE1   = 4'h1,
    M_IDLE0   = 4'h3,
    M_NORMAL2 = 4'h2,
    M_SLOW2   = 4'h6,
    M_SLOW1   = 4'h7,
    M_SLEEP1  = 4'h5,
    M_SLEEP0  = 4'h4,
    M_IDLE2   = 4'hC,
    M_SLEEP2  = 4'hD,
    M_STOP    = 4'hF
  } mode_e;

  typedef struct packed {
    mode_e       mode;
    mode_e       stop_from;
    logic        stop_bit;
    logic [7:0]  sys_two;
    logic [3:0]  tbt_ctrl;
    logic [2:0]  irq_ctrl;
    logic        tbt_en_at_entry;
    logic [PRE_STAGES-1:0] pre;
    logic [DIV_STAGES-1:0] div;
    logic [7:0]  low_cnt;
    logic        low_tick;
    logic [15:0] warm;
    logic        tap_d;
    logic [1:0]  state_cnt;
    logic [3:0]  mc_cnt;
    logic        stop_pin_s1;
    logic        stop_pin_s2;
    logic        irq_s1;
    logic        irq_s2;
    logic [7:0]  rdata;
    logic        cpu_run;
    logic        per_clk_en;
    logic        tbt_clk_en;
    logic        low_port_mode;
    logic        mc_pulse;
  } ctl_s;

endpackage : clk_mode_pkg

// ---- clk_mode_ctrl.sv ----
// system clock mode controller: prescaler, 21-stage divider, machine cycle counters, mode sequencing
// assumes a bus master on i_ref_clk; stop pin and interrupt request arrive asynchronously
//
// Behaviour
// [R1] two-stage prescaler then twenty-one stage divider
// [R2] prescaler and divider cleared on reset, stop
// [R3] stage seven input selected by mode, bits
// [R4] slow and sleep feed low clock
// [R5] stop warm-up feeds stage six output
// [R6] software never sets stage-seven select single-clock
// [R7] software sets stage-seven select after low stable
// [R8] machine cycle is four states
// [R9] instructions take one to ten cycles
// [R10] single clock: high osc only, ports free
// [R11] reset lands in single-clock normal mode
// [R12] idle bit halts cpu, interrupt releases
// [R13] release resumes by interrupt master enable
// [R14] halt bit gates all but base timer
// [R15] base timer source falling edge resumes
// [R16] halt entry independent; irq needs three enables
// [R17] latch set after halt exit if enabled
// [R18] dual clock: low clock in slow, sleep
// [R19] dual clock: both osc, ports taken
// [R20] software enables low osc at start
// [R21] source select moves to slow and back
// [R22] clearing high enable enters slow one
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module clk_mode_ctrl
  import clk_mode_pkg::*;
#(
  parameter int LOW_RATIO = LOW_DIV           // reference cycles per low-clock tick
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESETN,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_stop_release,  // async stop release pin, high releases
  input  wire logic        i_irq_req,       // async any interrupt request
  input  wire logic [3:0]  i_insn_cycles,   // cycles of current instruction, 1..10
  output logic [7:0]       o_rdata,
  output logic             o_cpu_run,       // cpu clock enable
  output logic             o_periph_clk_en, // peripheral clock enable
  output logic             o_tbt_clk_en,    // base timer clock enable
  output logic             o_low_port_mode, // low osc pins act as ports
  output logic             o_insn_done,     // pulse at end of instruction
  output logic             o_irq_service,   // pending irq taken on release
  output logic             o_dvo            // divider_pulse_output
);
  import clk_mode_pkg::*;

  // ****************************************
  // state registers
  // ****************************************
  ctl_s st_reg;   // all state except svc_reg
  ctl_s st_next;  // next state

  logic       main_tick;   // one main system clock period
  logic       s7_in;       // stage seven input edge
  logic       tap;         // base timer selected source
  logic       tap_fall;    // falling edge of source
  logic       in_slow;     // low clock modes
  logic       dual;        // dual clock selected
  logic       irq_now;     // synchronised irq
  logic [DIV_STAGES-1:0] div_inc; // divider plus one

  assign div_inc = st_reg.div + {{(DIV_STAGES-1){1'b0}}, 1'b1};

  // ****************************************
  // next state logic
  // ****************************************
  always_comb
  begin
    st_next          = st_reg;
    st_next.rdata    = 8'h00;
    st_next.mc_pulse = 1'b0;
    st_next.low_tick = 1'b0;
    // synchronisers, first stage read only by second
    st_next.stop_pin_s1 = i_stop_release;
    st_next.stop_pin_s2 = st_reg.stop_pin_s1;
    st_next.irq_s1      = i_irq_req;
    st_next.irq_s2      = st_reg.irq_s1;
    irq_now = st_reg.irq_s2;
    in_slow = (st_reg.mode == M_SLOW1) || (st_reg.mode == M_SLOW2) ||
              (st_reg.mode == M_SLEEP1) || (st_reg.mode == M_SLEEP2) || (st_reg.mode == M_SLEEP0);
    dual    = st_reg.sys_two[BIT_XTEN];
    // low clock tick divider
    if (st_reg.low_cnt == 8'(LOW_RATIO - 1))
    begin
      st_next.low_cnt  = 8'h00;
      st_next.low_tick = 1'b1;
    end
    else
    begin
      st_next.low_cnt = st_reg.low_cnt + 8'h01;
    end
    // main tick source
    // [R18] main clock from low in slow
    main_tick = in_slow ? st_reg.low_tick : 1'b1;
    // [R1] prescaler then divider
    if (st_reg.mode != M_STOP && !in_slow)
      st_next.pre = st_reg.pre + 2'(1);
    // [R3] stage seven input select
    if (in_slow)
      s7_in = st_reg.low_tick;                        // [R4] low clock forced
    else if (st_reg.warm != 16'h0000)
      s7_in = (div_inc[5:0] == 6'h00) && (st_reg.pre == 2'h3); // [R5] sixth stage during warm-up
    else if (st_reg.tbt_ctrl[BIT_DV7])
      s7_in = st_reg.low_tick;
    else
      s7_in = (div_inc[5:0] == 6'h00) && (st_reg.pre == 2'h3);
    if (st_reg.mode != M_STOP)
    begin
      if (!in_slow && st_reg.pre == 2'h3)
        st_next.div[5:0] = div_inc[5:0];              // stages one to six stop in slow
      if (s7_in)
        st_next.div[DIV_STAGES-1:6] = st_reg.div[DIV_STAGES-1:6] + 15'(1);
    end
    tap = st_reg.div[6 + 2 * st_reg.tbt_ctrl[BIT_TBTSEL +: 2]];
    st_next.tap_d = tap;
    tap_fall = st_reg.tap_d && !tap;
    // [R8] four states per machine cycle
    if (st_reg.cpu_run && main_tick)
    begin
      st_next.state_cnt = st_reg.state_cnt + 2'(1);
      if (st_reg.state_cnt == 2'(STATES_PER_MC - 1))
      begin
        // [R9] one to ten machine cycles
        if (st_reg.mc_cnt + 4'h1 >= i_insn_cycles || st_reg.mc_cnt == 4'h9)
        begin
          st_next.mc_cnt   = 4'h0;
          st_next.mc_pulse = 1'b1;
        end
        else
          st_next.mc_cnt = st_reg.mc_cnt + 4'h1;
      end
    end
    if (st_reg.warm != 16'h0000)
      st_next.warm = st_reg.warm - 16'h0001;
    // register writes
    if (i_wr)
    begin
      case (i_addr)
        OFS_SYS_ONE:  st_next.stop_bit = i_wdata[BIT_STOP];
        OFS_SYS_TWO:  st_next.sys_two  = {3'h0, i_wdata[4:0]};
        OFS_TBT_CTRL: st_next.tbt_ctrl = i_wdata[3:0];
        OFS_IRQ_CTRL: st_next.irq_ctrl = i_wdata[2:0];
        default:      ;
      endcase
    end
    // mode sequencing
    case (st_reg.mode)
      M_NORMAL1, M_NORMAL2:
      begin
        if (st_reg.stop_bit)
        begin
          st_next.stop_from = st_reg.mode;
          st_next.mode      = M_STOP;
          // [R2] clear on stop entry
          st_next.pre = '0;
          st_next.div = '0;
        end
        else if (st_reg.sys_two[BIT_TIMING_GEN_HALT])
        begin
          // [R14] halt gates all but base timer
          st_next.mode = (st_reg.mode == M_NORMAL1) ? M_IDLE0 : M_IDLE0;
          st_next.tbt_en_at_entry = st_reg.tbt_ctrl[BIT_BASE_TIMER_ENABLE]; // [R16] entry ignores enable
        end
        else if (st_reg.sys_two[BIT_IDLE])
          st_next.mode = (st_reg.mode == M_NORMAL1) ? M_IDLE1 : M_IDLE2; // [R12] idle entry
        else if (dual && st_reg.sys_two[BIT_MAIN_CLOCK_SOURCE_SELECT])
          st_next.mode = M_SLOW2;                     // [R21] to slow
        else
          st_next.mode = dual ? M_NORMAL2 : M_NORMAL1;
      end
      M_IDLE1, M_IDLE2, M_SLEEP1, M_SLEEP2:
      begin
        // [R12] interrupt releases idle
        if (irq_now)
        begin
          st_next.sys_two[BIT_IDLE] = 1'b0;
          st_next.mode = (st_reg.mode == M_IDLE1) ? M_NORMAL1 :
                         (st_reg.mode == M_IDLE2) ? M_NORMAL2 :
                         (st_reg.mode == M_SLEEP1) ? M_SLOW1 : M_SLOW2;
        end
      end
      M_IDLE0, M_SLEEP0:
      begin
        // [R15] resume on source falling edge
        if (tap_fall)
        begin
          st_next.sys_two[BIT_TIMING_GEN_HALT] = 1'b0;
          st_next.mode = (st_reg.mode == M_IDLE0) ? M_NORMAL1 : M_SLOW1;
          // [R17] set latch after return
          if (st_reg.tbt_en_at_entry)
            st_next.irq_ctrl[BIT_LATCH] = 1'b1;
        end
      end
      M_SLOW2:
      begin
        if (st_reg.sys_two[BIT_TIMING_GEN_HALT])
        begin
          st_next.mode = M_SLEEP0;
          st_next.tbt_en_at_entry = st_reg.tbt_ctrl[BIT_BASE_TIMER_ENABLE];
        end
        else if (st_reg.sys_two[BIT_IDLE])
          st_next.mode = M_SLEEP2;
        else if (!st_reg.sys_two[BIT_MAIN_CLOCK_SOURCE_SELECT])
          st_next.mode = M_NORMAL2;                   // [R21] back to normal two
        else if (!st_reg.sys_two[BIT_XEN])
          st_next.mode = M_SLOW1;                     // [R22] high osc off
      end
      M_SLOW1:
      begin
        if (st_reg.sys_two[BIT_TIMING_GEN_HALT])
        begin
          st_next.mode = M_SLEEP0;
          st_next.tbt_en_at_entry = st_reg.tbt_ctrl[BIT_BASE_TIMER_ENABLE];
        end
        else if (st_reg.sys_two[BIT_IDLE])
          st_next.mode = M_SLEEP1;
        else if (st_reg.sys_two[BIT_XEN])
          st_next.mode = M_SLOW2;
      end
      M_STOP:
      begin
        if (st_reg.stop_pin_s2)
        begin
          st_next.stop_bit = 1'b0;
          st_next.mode     = st_reg.stop_from;
          st_next.pre      = '0;                      // [R2] clear on stop release
          st_next.div      = '0;
          st_next.warm     = WARMUP_CYC;
        end
      end
      default: st_next.mode = M_NORMAL1;
    endcase
    // reads, one cycle later
    if (i_rd)
    begin
      case (i_addr)
        OFS_SYS_ONE:  st_next.rdata = {7'h00, st_reg.stop_bit};
        OFS_SYS_TWO:  st_next.rdata = st_reg.sys_two;
        OFS_TBT_CTRL: st_next.rdata = {4'h0, st_reg.tbt_ctrl};
        OFS_IRQ_CTRL: st_next.rdata = {5'h00, st_reg.irq_ctrl};
        OFS_STATUS:   st_next.rdata = {st_reg.div[DIV_STAGES-1], 3'h0, st_reg.mode};
        default:      st_next.rdata = 8'h00;
      endcase
    end
    // output enables, cpu held until stop warm-up has run out
    st_next.cpu_run    = ((st_next.mode == M_NORMAL1) || (st_next.mode == M_NORMAL2) ||
                          (st_next.mode == M_SLOW1) || (st_next.mode == M_SLOW2)) && (st_next.warm == 16'h0000);
    st_next.per_clk_en = st_next.cpu_run || (st_next.mode == M_IDLE1) || (st_next.mode == M_IDLE2) ||
                         (st_next.mode == M_SLEEP1) || (st_next.mode == M_SLEEP2);
    st_next.tbt_clk_en = st_next.per_clk_en || (st_next.mode == M_IDLE0) || (st_next.mode == M_SLEEP0);
    // [R10] single clock frees low osc pins
    // [R19] dual clock takes them
    st_next.low_port_mode = !st_next.sys_two[BIT_XTEN];
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      // [R11] start in single-clock normal
      st_reg               <= '0;
      st_reg.mode          <= M_NORMAL1;
      st_reg.stop_from     <= M_NORMAL1;
      st_reg.sys_two       <= SYS_TWO_RST;
      st_reg.cpu_run       <= 1'b1;
      st_reg.per_clk_en    <= 1'b1;
      st_reg.tbt_clk_en    <= 1'b1;
      st_reg.low_port_mode <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // [R13] release serviced when master enable set
  // [R16] irq needs three enables
  logic svc_reg;
  always_ff @(posedge I_REF_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      svc_reg <= 1'b0;
    else
      svc_reg <= st_reg.irq_ctrl[BIT_IMF] &&
                 ((st_reg.irq_ctrl[BIT_EF6] && st_reg.tbt_ctrl[BIT_BASE_TIMER_ENABLE] && st_reg.irq_ctrl[BIT_LATCH]) ||
                  st_reg.irq_s2);  // pending request taken only with master enable
  end

  assign o_rdata         = st_reg.rdata;
  assign o_cpu_run       = st_reg.cpu_run;
  assign o_periph_clk_en = st_reg.per_clk_en;
  assign o_tbt_clk_en    = st_reg.tbt_clk_en;
  assign o_low_port_mode = st_reg.low_port_mode;
  assign o_insn_done     = st_reg.mc_pulse;
  assign o_irq_service   = svc_reg;
  assign o_dvo           = st_reg.div[DIV_STAGES-1];

  // ****************************************
  // assertions
  // ****************************************
  sequence stop_rel_s;
    st_reg.mode == M_STOP && st_reg.stop_pin_s2;
  endsequence
  // [R2] divider cleared at stop release
  stop_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) stop_rel_s |=> st_reg.div == '0) // [R2]
    else $error("divider not cleared at stop release");
  // [R11] normal one after reset
  reset_mode_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN) $rose(I_RESETN) |-> st_reg.mode == M_NORMAL1) // [R11]
    else $error("not in normal one after reset");
  // [R12] idle entry halts cpu
  idle_halt_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    st_reg.mode == M_IDLE1 |-> !o_cpu_run && o_periph_clk_en) // [R12]
    else $error("idle gating wrong");
  // [R14] halt gates peripherals
  halt_gate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    st_reg.mode == M_IDLE0 |-> !o_periph_clk_en && o_tbt_clk_en) // [R14]
    else $error("halt gating wrong");
  // [R15] falling edge resumes normal one
  tap_resume_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    st_reg.mode == M_IDLE0 && tap_fall |=> st_reg.mode == M_NORMAL1) // [R15]
    else $error("no resume on source edge");
  // [R17] latch set after halt exit
  latch_set_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    st_reg.mode == M_IDLE0 && tap_fall && st_reg.tbt_en_at_entry |=> st_reg.irq_ctrl[BIT_LATCH]) // [R17]
    else $error("latch not set");
  // [R8] states wrap after four
  state_wrap_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    st_reg.mc_pulse |-> $past(st_reg.state_cnt) == 2'h3) // [R8]
    else $error("machine cycle not four states");
  // [R22] clearing high enable enters slow one
  slow_one_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    st_reg.mode == M_SLOW2 && !st_reg.sys_two[BIT_XEN] && st_reg.sys_two[BIT_MAIN_CLOCK_SOURCE_SELECT] &&
    !st_reg.sys_two[BIT_IDLE] && !st_reg.sys_two[BIT_TIMING_GEN_HALT] |=> st_reg.mode == M_SLOW1) // [R22]
    else $error("no slow one entry");

endmodule : clk_mode_ctrl

// ---- tb_top.sv ----
// testbench for the system clock mode controller: register port, modes, machine cycles, halt and stop release
// assumes clk_mode_pkg and clk_mode_ctrl are compiled first; dut assertions live in the design files
`timescale 1ns/100ps
module tb_top;
  import clk_mode_pkg::*;
  // ****************************************
  // signals and bookkeeping
  // ****************************************
  typedef struct { logic [7:0] msk; logic [7:0] exp; string name; } rnote_s;  // pending read check
  logic        clk, rst_n, wr, rd, rd_q, stop_rel, irq_req;
  logic [3:0]  addr, insn_cycles;
  logic [7:0]  wdata, rdata, last_rd;
  logic        cpu_run, per_en, tbt_en, port_mode, insn_done, irq_svc, divider_pulse_output;
  rnote_s      rq[$];                     // expected read results, oldest first
  int          iq[$];                     // expected instruction lengths in clocks
  int          n_mismatch, n_compared, gap, k, n, seed;
  logic [7:0]  dw[6] = '{8'h18, 8'h1C, 8'h14, 8'h15, 8'h1C, 8'h18};  // dual-clock walk, writes
  mode_e       dm[6] = '{M_NORMAL2, M_SLOW2, M_SLOW1, M_SLEEP1, M_SLOW2, M_NORMAL2};
  clk_mode_ctrl #(.LOW_RATIO(4)) dut (
    .I_REF_CLK(clk), .I_RESETN(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .i_stop_release(stop_rel), .i_irq_req(irq_req), .i_insn_cycles(insn_cycles), .o_rdata(rdata),
    .o_cpu_run(cpu_run), .o_periph_clk_en(per_en), .o_tbt_clk_en(tbt_en), .o_low_port_mode(port_mode),
    .o_insn_done(insn_done), .o_irq_service(irq_svc), .o_dvo(divider_pulse_output));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************************************
  // compare and closing tasks
  // ****************************************
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask : cmp_byte
  task cmp_bit(input string nm, input logic e, input logic s);
    cmp_byte(nm, {7'h00, e}, {7'h00, s});
  endtask : cmp_bit
  task cmp_count(input string nm, input int e, input int s);
    n_compared++;
    if (s != e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0d seen %0d", nm, e, s);
    end
  endtask : cmp_count
  // ****************************************
  // bus and wait tasks
  // ****************************************
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    rq.push_back('{m, e, nm});
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg
  task wait_run(input logic e, input int bound);
    k = 0;
    while (cpu_run !== e && k < bound)
    begin
      tick(1);
      k++;
    end
    if (cpu_run !== e)
    begin
      cmp_bit("cpu_run wait", e, cpu_run);
      summarize();
    end
  endtask : wait_run
  task wait_done;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (insn_done !== 1'b1 && n < 200);
    if (insn_done !== 1'b1)
    begin
      cmp_bit("insn_done wait", 1'b1, insn_done);
      summarize();
    end
  endtask : wait_done
  task poll_mode(input mode_e m);
    n = 0;
    do
    begin
      rd_reg(OFS_STATUS, 8'h00, 8'h00, "");
      tick(1);
      n++;
    end
    while (last_rd[3:0] !== m && n < 300);
    if (last_rd[3:0] !== m)
    begin
      cmp_byte("mode wait", {4'h0, m}, {4'h0, last_rd[3:0]});
      summarize();
    end
    rd_reg(OFS_STATUS, 8'h0F, {4'h0, m}, "mode");
  endtask : poll_mode
  task tend(input string nm);
    tick(2);
    $display("test %s finished", nm);
  endtask : tend
  // ****************************************
  // result watchers
  // ****************************************
  always @(posedge clk) rd_q <= rd;
  // read data stand in the cycle after the strobe only
  always @(negedge clk)
  begin
    if (rd_q === 1'b1 && rq.size() > 0)
    begin
      last_rd = rdata;
      if (rq[0].msk != 8'h00) cmp_byte(rq[0].name, rq[0].exp, rdata & rq[0].msk);
      void'(rq.pop_front());
    end
  end
  // instruction spacing measured in reference clocks
  always @(negedge clk)
  begin
    if (insn_done === 1'b1)
    begin
      if (iq.size() > 0) cmp_count("insn gap", iq.pop_front(), gap);
      gap = 1;
    end
    else gap++;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 32'h00D7;
    {rst_n, wr, rd, stop_rel, irq_req, addr, wdata} = '0;
    insn_cycles = 4'h1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    // reset state
    cmp_bit("cpu_run", 1'b1, cpu_run);
    cmp_bit("tbt_en", 1'b1, tbt_en);
    cmp_bit("port_mode", 1'b1, port_mode);
    rd_reg(OFS_STATUS, 8'hFF, 8'h00, "status");
    rd_reg(OFS_SYS_TWO, 8'hFF, SYS_TWO_RST, "sys_two");
    for (int a = 5; a < 16; a++) rd_reg(a[3:0], 8'hFF, 8'h00, "unmapped");
    tend("reset");
    // machine cycle of four states, 1..10 cycles
    for (int i = 0; i < 8; i++)
    begin
      k = (i == 0) ? 1 : (i == 1) ? 10 : 1 + ($unsigned($random(seed)) % 10);
      @(posedge clk);
      insn_cycles <= k[3:0];
      wait_done();
      wait_done();
      @(posedge clk);
      iq.push_back(STATES_PER_MC * k);
      wait_done();
      @(posedge clk);
    end
    tend("machine cycle");
    // idle entry and interrupt release, master enable clear
    wr_reg(OFS_SYS_TWO, SYS_TWO_RST | (8'h01 << BIT_IDLE));
    tick(2);
    cmp_bit("idle cpu_run", 1'b0, cpu_run);
    cmp_bit("idle per_en", 1'b1, per_en);
    @(posedge clk);
    irq_req <= 1'b1;
    wait_run(1'b1, 20);
    cmp_bit("idle irq_service", 1'b0, irq_svc);
    @(posedge clk);
    irq_req <= 1'b0;
    rd_reg(OFS_SYS_TWO, 8'hFF, SYS_TWO_RST, "sys_two");
    poll_mode(M_NORMAL1);
    tend("idle");
    // halt with and without base timer enable
    wr_reg(OFS_IRQ_CTRL, 8'h03);
    for (int t = 0; t < 2; t++)
    begin
      wr_reg(OFS_TBT_CTRL, (t == 0) ? 8'h01 : 8'h00);  // stage-seven select kept clear
      wr_reg(OFS_SYS_TWO, SYS_TWO_RST | (8'h01 << BIT_TIMING_GEN_HALT));
      tick(2);
      cmp_bit("halt cpu_run", 1'b0, cpu_run);
      cmp_bit("halt per_en", 1'b0, per_en);
      cmp_bit("halt tbt_en", 1'b1, tbt_en);
      wait_run(1'b1, 2000);
      tick(2);
      cmp_bit("resume per_en", 1'b1, per_en);
      poll_mode(M_NORMAL1);
      rd_reg(OFS_IRQ_CTRL, 8'hFF, (t == 0) ? 8'h07 : 8'h03, "irq_ctrl");
      tick(2);
      cmp_bit("irq_service", (t == 0), irq_svc);
      wr_reg(OFS_IRQ_CTRL, 8'h03);
    end
    tend("halt");
    // dual clock walk, low osc turned on by the first write
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(OFS_SYS_TWO, dw[i]);
      poll_mode(dm[i]);
      cmp_bit("port_mode dual", 1'b0, port_mode);
      if (dm[i] == M_SLEEP1)
      begin
        cmp_bit("sleep cpu_run", 1'b0, cpu_run);
        @(posedge clk);
        irq_req <= 1'b1;
        wait_run(1'b1, 400);
        cmp_bit("sleep irq_service", 1'b1, irq_svc);
        @(posedge clk);
        irq_req <= 1'b0;
        poll_mode(M_SLOW1);
      end
    end
    wr_reg(OFS_SYS_TWO, SYS_TWO_RST);
    poll_mode(M_NORMAL1);
    cmp_bit("port_mode single", 1'b1, port_mode);
    tend("dual clock");
    // stop entry, warm-up and divider clear
    wr_reg(OFS_SYS_ONE, 8'h01 << BIT_STOP);
    tick(3);
    cmp_bit("stop cpu_run", 1'b0, cpu_run);
    cmp_bit("stop per_en", 1'b0, per_en);
    @(posedge clk);
    stop_rel <= 1'b1;
    wait_run(1'b1, int'(WARMUP_CYC) + 40);
    cmp_count("warm-up long enough", 1, (k >= int'(WARMUP_CYC)) ? 1 : 0);
    @(posedge clk);
    stop_rel <= 1'b0;
    rd_reg(OFS_STATUS, 8'h80, 8'h00, "divider top");
    tend("stop");
    summarize();
  end
endmodule : tb_top
